// ### hdl/scg_defines.svh
// offsets, field limits, reset values and counts for the scl period timing block
// Operation
// RL1: standard speed high phase uses standard high count
// RL2: standard speed low phase uses standard low count
// RL3: fast speed high phase uses fast high count
// RL4: fast speed low phase uses fast low count
// RL5: high speed special bytes use fast counts
// RL6: count writes ignored while controller enabled
// RL7: high counts below 6 stored as 6
// RL8: low counts below 8 stored as 8
// RL9: bus idle when counter reaches high+10
// RL10: host keeps standard high count <= 65525
// RL11: host programs counts before any transfer
// RL12: byte-wide host writes low byte first
// RL13: count pair chosen at each phase start
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// ==========================================================
// register byte addresses
`define SCG_STD_HIGH_ADDR   32'h5000_1314
`define SCG_STD_LOW_ADDR    32'h5000_1318
`define SCG_FAST_HIGH_ADDR  32'h5000_131C
`define SCG_FAST_LOW_ADDR   32'h5000_1320

// ==========================================================
// reset values
`define SCG_STD_HIGH_RST    16'h0048
`define SCG_STD_LOW_RST     16'h004F
`define SCG_FAST_HIGH_RST   16'h0008
`define SCG_FAST_LOW_RST    16'h0017

// ==========================================================
// limits and counts
`define SCG_HIGH_MIN        16'h0006
`define SCG_LOW_MIN         16'h0008
`define SCG_IDLE_MARGIN     16'h000A
`define SCG_CNT_W           16

`endif

// ### hdl/scg_pkg.sv
// types shared by the scl period timing block
package scg_pkg;

  // ==========================================================
  // speed modes
  typedef enum logic [1:0] {
    SCG_SPEED_STD,
    SCG_SPEED_FAST,
    SCG_SPEED_HIGH
  } scg_speed_t;

  // ==========================================================
  // scl generator states
  typedef enum logic [1:0] {
    SCG_ST_IDLE,
    SCG_ST_LOW,
    SCG_ST_WAIT_HIGH,
    SCG_ST_HIGH
  } scg_state_t;

endpackage

// ### hdl/scg_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module scg_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ### hdl/scg_scl_timing.sv
// scl high/low period generator with count registers and bus idle detection
`timescale 1ns/100ps
`include "scg_defines.svh"
module scg_scl_timing
  import scg_pkg::*;
(
  // core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_r,
  output logic             reg_rvalid_r,
  // controller enable from core logic
  input  wire logic        controller_enable_bit,
  output logic             link_busy_r,
  // link clock and transfer control
  input  wire logic        link_clk,
  input  wire logic        master_clock_run,
  input  scg_speed_t       speed_mode,
  input  wire logic        hs_special_phase,
  input  wire logic [15:0] hs_high_count,
  input  wire logic [15:0] hs_low_count,
  output logic             low_phase_done_r,
  output logic             scl_high_phase_r,
  output logic             bus_idle_r,
  // bus pins
  input  wire logic        scl_in,
  output logic             scl_out_r,
  output logic             scl_oe_n_r,
  input  wire logic        sda_in
);

  // ==========================================================
  // functions
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] be);
    return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] lim);
    return (v < lim) ? lim : v;
  endfunction

  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ref_a);
    return a == ref_a;
  endfunction

  // ==========================================================
  // core domain count registers

  logic [15:0] std_high_period_count_r;
  logic [15:0] std_low_period_count_r;
  logic [15:0] fast_high_period_count_r;
  logic [15:0] fast_low_period_count_r;
  logic        wr_ok;

  // writes only land while the controller is disabled
  assign wr_ok = reg_wr & ~controller_enable_bit; // [RL6]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      std_high_period_count_r <= `SCG_STD_HIGH_RST;
    end else if (wr_ok && addr_hit(reg_addr, `SCG_STD_HIGH_ADDR)) begin
      std_high_period_count_r <= clamp_min(
        merge_bytes(std_high_period_count_r, reg_wdata, reg_be),
        `SCG_HIGH_MIN); // [RL7]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      std_low_period_count_r <= `SCG_STD_LOW_RST;
    end else if (wr_ok && addr_hit(reg_addr, `SCG_STD_LOW_ADDR)) begin
      std_low_period_count_r <= clamp_min(
        merge_bytes(std_low_period_count_r, reg_wdata, reg_be),
        `SCG_LOW_MIN); // [RL8]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fast_high_period_count_r <= `SCG_FAST_HIGH_RST;
    end else if (wr_ok && addr_hit(reg_addr, `SCG_FAST_HIGH_ADDR)) begin
      fast_high_period_count_r <= clamp_min(
        merge_bytes(fast_high_period_count_r, reg_wdata, reg_be),
        `SCG_HIGH_MIN); // [RL7]
    end
  end

  // byte writes merge, so a low byte first then high byte builds the word
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fast_low_period_count_r <= `SCG_FAST_LOW_RST;
    end else if (wr_ok && addr_hit(reg_addr, `SCG_FAST_LOW_ADDR)) begin
      fast_low_period_count_r <= clamp_min(
        merge_bytes(fast_low_period_count_r, reg_wdata, reg_be),
        `SCG_LOW_MIN); // [RL8] [RL12]
    end
  end

  // ==========================================================
  // core domain read path

  logic [15:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 16'h0000;
    if (addr_hit(reg_addr, `SCG_STD_HIGH_ADDR)) begin
      rdata_nxt = std_high_period_count_r;
    end else if (addr_hit(reg_addr, `SCG_STD_LOW_ADDR)) begin
      rdata_nxt = std_low_period_count_r;
    end else if (addr_hit(reg_addr, `SCG_FAST_HIGH_ADDR)) begin
      rdata_nxt = fast_high_period_count_r;
    end else if (addr_hit(reg_addr, `SCG_FAST_LOW_ADDR)) begin
      rdata_nxt = fast_low_period_count_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r  <= 16'h0000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // link domain reset release

  logic link_rst_meta_r;
  logic link_rst_n_r;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      link_rst_meta_r <= 1'b0;
      link_rst_n_r    <= 1'b0;
    end else begin
      link_rst_meta_r <= 1'b1;
      link_rst_n_r    <= link_rst_meta_r;
    end
  end

  // ==========================================================
  // crossings

  logic       en_s;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       link_busy_src_r;

  scg_sync #(.WIDTH(1)) u_en_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n_r),
    .d     (controller_enable_bit),
    .q     (en_s)
  );

  scg_sync #(.WIDTH(2)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n_r),
    .d     ({sda_in, scl_in}),
    .q     (pins_s)
  );

  scg_sync #(.WIDTH(1)) u_busy_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (link_busy_src_r),
    .q     (link_busy_r)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];

  // ==========================================================
  // link domain shadow counts
  // counts are frozen while enabled, so they are copied once the
  // synchronised enable rises; no write can move them after that

  logic        en_d_r;
  logic [15:0] std_high_sh_r;
  logic [15:0] std_low_sh_r;
  logic [15:0] fast_high_sh_r;
  logic [15:0] fast_low_sh_r;

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= en_s;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      std_high_sh_r  <= `SCG_STD_HIGH_RST;
      std_low_sh_r   <= `SCG_STD_LOW_RST;
      fast_high_sh_r <= `SCG_FAST_HIGH_RST;
      fast_low_sh_r  <= `SCG_FAST_LOW_RST;
    end else if (en_s && !en_d_r) begin
      std_high_sh_r  <= std_high_period_count_r;
      std_low_sh_r   <= std_low_period_count_r;
      fast_high_sh_r <= fast_high_period_count_r;
      fast_low_sh_r  <= fast_low_period_count_r;
    end
  end

  // ==========================================================
  // count selection per phase
  logic [15:0] sel_high;
  logic [15:0] sel_low;

  always_comb begin
    case (speed_mode)
      SCG_SPEED_STD: begin
        sel_high = std_high_sh_r; // [RL1]
        sel_low  = std_low_sh_r; // [RL2]
      end
      SCG_SPEED_FAST: begin
        sel_high = fast_high_sh_r; // [RL3]
        sel_low  = fast_low_sh_r; // [RL4]
      end
      SCG_SPEED_HIGH: begin
        if (hs_special_phase) begin
          sel_high = fast_high_sh_r; // [RL5]
          sel_low  = fast_low_sh_r; // [RL5]
        end else begin
          sel_high = hs_high_count;
          sel_low  = hs_low_count;
        end
      end
      default: begin
        sel_high = std_high_sh_r;
        sel_low  = std_low_sh_r;
      end
    endcase
  end

  // ==========================================================
  // scl generator

  scg_state_t  state_r;
  scg_state_t  state_nxt;
  logic [15:0] phase_cnt_r;
  logic [15:0] phase_cnt_nxt;
  logic        run_ok;

  assign run_ok    = master_clock_run & en_s;

  always_comb begin
    state_nxt     = state_r;
    phase_cnt_nxt = phase_cnt_r;
    case (state_r)
      SCG_ST_IDLE: begin
        if (run_ok) begin
          state_nxt     = SCG_ST_LOW;
          phase_cnt_nxt = sel_low; // [RL13]
        end
      end
      SCG_ST_LOW: begin
        if (!en_s) begin
          state_nxt = SCG_ST_IDLE;
        end else if (phase_cnt_r <= 16'h0001) begin
          state_nxt = SCG_ST_WAIT_HIGH;
        end else begin
          phase_cnt_nxt = phase_cnt_r - 16'h0001;
        end
      end
      SCG_ST_WAIT_HIGH: begin
        // a slave may stretch the low phase; the high count starts
        // only once the line is seen high
        if (!en_s) begin
          state_nxt = SCG_ST_IDLE;
        end else if (scl_s) begin
          state_nxt     = SCG_ST_HIGH;
          phase_cnt_nxt = sel_high; // [RL13]
        end
      end
      SCG_ST_HIGH: begin
        if (!en_s) begin
          state_nxt = SCG_ST_IDLE;
        end else if (phase_cnt_r <= 16'h0001) begin
          if (run_ok) begin
            state_nxt     = SCG_ST_LOW;
            phase_cnt_nxt = sel_low; // [RL13]
          end else begin
            state_nxt = SCG_ST_IDLE;
          end
        end else begin
          phase_cnt_nxt = phase_cnt_r - 16'h0001;
        end
      end
      default: begin
        state_nxt     = SCG_ST_IDLE;
        phase_cnt_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      state_r     <= SCG_ST_IDLE;
      phase_cnt_r <= 16'h0000;
    end else begin
      state_r     <= state_nxt;
      phase_cnt_r <= phase_cnt_nxt;
    end
  end

  // ==========================================================
  // pin drive and phase flags

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      scl_out_r  <= 1'b0;
      scl_oe_n_r <= 1'b1;
    end else begin
      scl_out_r  <= 1'b0;
      scl_oe_n_r <= (state_nxt != SCG_ST_LOW); // [RL1] [RL2]
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      low_phase_done_r <= 1'b0;
      scl_high_phase_r <= 1'b0;
      link_busy_src_r  <= 1'b0;
    end else begin
      link_busy_src_r  <= (state_nxt != SCG_ST_IDLE); // flop before crossing, no decode glitch
      low_phase_done_r <= (state_r == SCG_ST_LOW) && (state_nxt == SCG_ST_WAIT_HIGH);
      scl_high_phase_r <= (state_nxt == SCG_ST_HIGH);
    end
  end

  // ==========================================================
  // bus idle detection
  // host keeps the standard high count low enough that the sum fits

  logic [15:0] idle_cnt_r;
  logic [15:0] idle_thr;

  assign idle_thr = std_high_sh_r + `SCG_IDLE_MARGIN; // [RL9] [RL10]

  always_ff @(posedge link_clk or negedge link_rst_n_r) begin
    if (!link_rst_n_r) begin
      idle_cnt_r <= 16'h0000;
      bus_idle_r <= 1'b0;
    end else if (!(scl_s && sda_s) || (state_r != SCG_ST_IDLE)) begin
      idle_cnt_r <= 16'h0000;
      bus_idle_r <= 1'b0;
    end else if (idle_cnt_r < idle_thr) begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
      bus_idle_r <= (idle_cnt_r + 16'h0001) == idle_thr; // [RL9]
    end else begin
      bus_idle_r <= 1'b1;
    end
  end

endmodule

// ### verif/scg_scl_timing_checker.sv
// port assertions for the scl period timing block
`timescale 1ns/100ps
`include "scg_defines.svh"
module scg_timing_checker (
  // clocks and reset
  input wire logic        core_clk,
  input wire logic        link_clk,
  input wire logic        rstn,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [1:0]  reg_be,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r,
  input wire logic        reg_rvalid_r,
  input wire logic        controller_enable_bit,
  // link side
  input wire logic        low_phase_done_r,
  input wire logic        scl_high_phase_r,
  input wire logic        bus_idle_r,
  input wire logic        scl_oe_n_r
);
  // ==========================================================
  // low phase length counter
  logic [15:0] low_len_r;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      low_len_r <= 16'h0000;
    end else if (!scl_oe_n_r) begin
      low_len_r <= low_len_r + 16'h0001;
    end else begin
      low_len_r <= 16'h0000;
    end
  end

  sequence s_hi_wr;
    reg_wr && !controller_enable_bit && reg_be == 2'b11 && reg_addr == `SCG_STD_HIGH_ADDR;
  endsequence
  sequence s_hi_rd;
    reg_rd && !reg_wr && reg_addr == `SCG_STD_HIGH_ADDR;
  endsequence

  chk_read_answer: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_rd |=> reg_rvalid_r) else $error("read not answered");
  chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_rd && !(reg_addr inside {`SCG_STD_HIGH_ADDR, `SCG_STD_LOW_ADDR,
    `SCG_FAST_HIGH_ADDR, `SCG_FAST_LOW_ADDR}) |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  chk_high_clamp: assert property (@(posedge core_clk) disable iff (!rstn)
    s_hi_wr ##1 s_hi_rd |=> reg_rdata_r == ($past(reg_wdata, 2) < 16'h0006 ?
    16'h0006 : $past(reg_wdata, 2))) else $error("high count not clamped");
  chk_low_min: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(scl_oe_n_r) |-> low_len_r >= 16'h0008) else $error("low phase too short");
  chk_release_done: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(scl_oe_n_r) |-> low_phase_done_r) else $error("release without done");
  chk_done_pulse: assert property (@(posedge link_clk) disable iff (!rstn)
    low_phase_done_r |=> !low_phase_done_r) else $error("done longer than one cycle");
  chk_high_released: assert property (@(posedge link_clk) disable iff (!rstn)
    scl_high_phase_r |-> scl_oe_n_r) else $error("scl driven in high phase");
  chk_idle_quiet: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(bus_idle_r) |-> scl_oe_n_r && !scl_high_phase_r)
    else $error("idle flagged while clocking");
endmodule

bind scg_scl_timing scg_timing_checker u_chk (.*);

// ### verif/scg_bus_partner.sv
// remote bus devices: pulled-up scl with clock stretching, sda holder
`timescale 1ns/100ps
module scg_bus_partner (
  // link clock
  input wire logic       link_clk,
  // scl from the block, low = driven low
  input wire logic       scl_oe_n,
  // stretch length and sda hold
  input wire logic [3:0] stretch,
  input wire logic       sda_low,
  // wired bus levels
  output logic           scl,
  output logic           sda
);
  logic [3:0] hold_r = 4'h0;
  // slave keeps scl low a few cycles after the master lets go
  always_ff @(posedge link_clk) begin
    if (!scl_oe_n) begin
      hold_r <= stretch;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
  assign scl = (!scl_oe_n || hold_r != 4'h0) ? 1'b0 : 1'b1;
  assign sda = !sda_low;
endmodule

// ### verif/scg_scl_timing_bench.sv
// self-checking bench for the scl period timing block
`timescale 1ns/100ps
`include "scg_defines.svh"
module scg_scl_timing_bench import scg_pkg::*;;
  logic core_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, controller_enable_bit = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [1:0]  reg_be = 2'b00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_r;
  logic [15:0] hs_high_count = 16'h0009, hs_low_count = 16'h0009;
  logic        master_clock_run = 1'b0, hs_special_phase = 1'b0, sda_low = 1'b0;
  scg_speed_t  speed_mode = SCG_SPEED_STD;
  logic [3:0]  stretch = 4'h0;
  logic reg_rvalid_r, link_busy_r, low_phase_done_r, scl_high_phase_r;
  logic bus_idle_r, scl_in, sda_in, scl_out_r, scl_oe_n_r;
  int bad_count = 0, check_count = 0, n;
  logic [15:0] v;
  logic [31:0] ra [4] = '{`SCG_STD_HIGH_ADDR, `SCG_STD_LOW_ADDR,
                          `SCG_FAST_HIGH_ADDR, `SCG_FAST_LOW_ADDR};
  logic [15:0] mdl [4] = '{`SCG_STD_HIGH_RST, `SCG_STD_LOW_RST,
                           `SCG_FAST_HIGH_RST, `SCG_FAST_LOW_RST};
  logic [15:0] mn [4] = '{`SCG_HIGH_MIN, `SCG_LOW_MIN, `SCG_HIGH_MIN, `SCG_LOW_MIN};
  scg_speed_t sp [5] = '{SCG_SPEED_STD, SCG_SPEED_FAST, SCG_SPEED_HIGH,
                         SCG_SPEED_HIGH, SCG_SPEED_STD};
  logic sx [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  scg_scl_timing u_dut (.*);
  scg_bus_partner u_bus (.link_clk(link_clk), .scl_oe_n(scl_oe_n_r), .stretch(stretch),
                         .sda_low(sda_low), .scl(scl_in), .sda(sda_in));

  always #12.5 core_clk = ~core_clk;
  always #40 link_clk = ~link_clk;

  // ==========================================================
  // helpers
  function automatic logic [15:0] want(input int i, input logic hi);
    if (sp[i] == SCG_SPEED_STD) return hi ? mdl[0] : mdl[1];
    if (sp[i] == SCG_SPEED_FAST || sx[i]) return hi ? mdl[2] : mdl[3];
    return hi ? hs_high_count : hs_low_count;
  endfunction
  function automatic logic pick(input int s);
    return s == 0 ? scl_oe_n_r : (s == 1 ? scl_high_phase_r : bus_idle_r);
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] b,
                     input logic [15:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_be = b;
    reg_wdata = d;
    @(negedge core_clk);
  endtask
  task automatic span(input int s, input logic lv);
    n = 0;
    while (pick(s) === lv && n < 300) begin
      n++;
      @(negedge link_clk);
    end
  endtask
  task automatic phase(input int i);
    stretch = 4'($urandom_range(0, 3));
    span(0, 1'b1);
    span(0, 1'b0);
    chk(16'(n), want(i, 1'b0));
    chk({15'h0000, link_busy_r}, 16'h0001);
    chk({15'h0000, scl_out_r}, 16'h0000);
    span(1, 1'b0);
    speed_mode = sp[i + 1];
    hs_special_phase = sx[i + 1];
    span(1, 1'b1);
    chk(16'(n), want(i, 1'b1));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h09a2));
    hs_high_count = 16'($urandom_range(6, 14));
    hs_low_count = 16'($urandom_range(8, 16));
    repeat (3) @(negedge link_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ra[i], 2'b11, 16'h0000);
      chk(reg_rdata_r, mdl[i]);
    end
    acc(1'b0, 32'h5000_1324, 2'b11, 16'h0000);
    chk(reg_rdata_r, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      n = (i < 4) ? i : int'($urandom_range(0, 3));
      v = (i < 4) ? 16'(5 + i) : 16'($urandom_range(0, 40));
      acc(1'b1, ra[n], 2'b11, v);
      mdl[n] = (v < mn[n]) ? mn[n] : v;
      acc(1'b0, ra[n], 2'b11, 16'h0000);
      chk(reg_rdata_r, mdl[n]);
    end
    v = 16'($urandom_range(8, 16));
    acc(1'b1, ra[3], 2'b01, v);
    acc(1'b1, ra[3], 2'b10, 16'h0000);
    mdl[3] = v;
    for (int i = 0; i < 3; i++) begin
      v = 16'($urandom_range(i == 1 ? 8 : 6, 14));
      acc(1'b1, ra[i], 2'b11, v);
      mdl[i] = v;
    end
    controller_enable_bit = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, ra[i], 2'b11, 16'h00ff);
      acc(1'b0, ra[i], 2'b11, 16'h0000);
      chk(reg_rdata_r, mdl[i]);
    end
    reg_rd = 1'b0;
    repeat (6) @(negedge link_clk);
    master_clock_run = 1'b1;
    for (int i = 0; i < 4; i++) phase(i);
    master_clock_run = 1'b0;
    repeat (60) @(negedge link_clk);
    chk({15'h0000, link_busy_r}, 16'h0000);
    sda_low = 1'b1;
    repeat (4) @(negedge link_clk);
    chk({15'h0000, bus_idle_r}, 16'h0000);
    sda_low = 1'b0;
    span(2, 1'b0);
    chk(16'(n >= mdl[0] + 10 && n <= mdl[0] + 15), 16'h0001);
    tally_and_finish;
  end
endmodule
